// file: logic/sp_spi_defs.svh
// Constants for the SPI serial port: register offsets, bit positions, mode codes, reset values, rates.
// Assumes an APB master with 8-bit byte addresses and a 32-bit data path.
// What this block does
// - Master samples late or mid-bit by sample bit
// - Transmit-edge bit picks which edge changes output
// - Polarity bit sets serial clock idle level
// - MSb-first shift; full byte fills buffer, flags
// - Reading data buffer clears buffer-full bit
// - Stop-seen bit cleared when port disabled
// - Busy data write dropped, sets write collision
// - Slave overrun sets overflow, drops new byte
// - Enable bit hands pins to the port
// - Mode codes for slave and timer master
// - Master rates divide clock by 64/16/4
// - Master data write starts transfer at once
// - Late-edge master presents data before clock
// - Slave shifts on external clock, flags byte
// - Drive on programmed edge, capture on other; late-sample master captures on drive edge
// - Select high releases data-out four clocks later
// - Select high in select mode or disable resets bit counter
// - Data write loads buffer and shift register
// - Standard SPI modes map to polarity, edge
// - Reset disables port and aborts transfer
`ifndef SP_SPI_DEFS_SVH
`define SP_SPI_DEFS_SVH
`define SP_OFF_STATUS      8'h00
`define SP_OFF_CONTROL     8'h04
`define SP_OFF_DATA        8'h08
`define SP_OFF_FLAGS       8'h0C
`define SP_OFF_TIMER       8'h10
`define SP_ST_SAMPLE_LATE  7
`define SP_ST_TX_IDLE_EDGE 6
`define SP_ST_STOP_SEEN    4
`define SP_ST_RX_FULL      0
`define SP_CT_WRITE_COLLISION         7
`define SP_CT_OVERFLOW     6
`define SP_CT_ENABLE       5
`define SP_CT_IDLE_HIGH    4
`define SP_FL_IRQ          0
`define SP_MODE_DIV4       4'h0
`define SP_MODE_DIV16      4'h1
`define SP_MODE_DIV64      4'h2
`define SP_MODE_TIMER      4'h3
`define SP_MODE_SLAVE_SEL  4'h4
`define SP_MODE_SLAVE_FREE 4'h5
`define SP_HALF_DIV4       8'h02
`define SP_HALF_DIV16      8'h08
`define SP_HALF_DIV64      8'h20
`define SP_TIMER_RESET     8'hFF
`define SP_LAST_BIT        3'h7
`define SP_LAST_STEP       5'h10
`endif

// file: logic/sp_spi_pkg.sv
// Types shared by the SPI serial port: pin bundles, engine states and the register state.
// Assumes the constants header is included alongside.
package sp_spi_pkg;
   typedef struct packed {
      logic sck;
      logic ss_n;
      logic sdi;
   } sp_pin_in_s;

   typedef struct packed {
      logic sck_out;
      logic sck_oe;
      logic sdo_out;
      logic sdo_oe;
   } sp_pin_out_s;

   typedef enum logic [1:0] {
      SP_IDLE   = 2'b00,
      SP_MASTER = 2'b01,
      SP_SLAVE  = 2'b10
   } sp_eng_e;

   typedef struct packed {
      logic        sample_late;
      logic        tx_idle_edge;
      logic        stop_seen;
      logic        rx_buffer_full;
      logic        write_collision;
      logic        rx_overflow;
      logic        port_enable;
      logic        clock_idle_high;
      logic [3:0]  port_mode_select;
      logic        port_irq_flag;
      logic [7:0]  data_buffer;
      logic [7:0]  shift_register;
      logic [7:0]  timer_period;
      logic [7:0]  timer_cnt;
      logic [7:0]  div_cnt;
      logic [4:0]  step;
      logic [2:0]  bit_cnt;
      logic        mid_sample;
      sp_eng_e     eng;
      sp_pin_in_s  sync1;
      sp_pin_in_s  sync2;
      sp_pin_in_s  sync3;
      sp_pin_in_s  filt;
      logic        sck_prev;
      sp_pin_out_s pins;
      logic        pins_owned;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } sp_state_s;
endpackage : sp_spi_pkg

// file: logic/sp_spi_port.sv
// SPI serial port, master or slave, with APB register access.
// Assumes pins arrive asynchronously and the pad logic resolves each pin from its output enable.
`timescale 1ns/10ps
`include "sp_spi_defs.svh"
module sp_spi_port
   import sp_spi_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   input  wire sp_pin_in_s  pin_in,
   output      sp_pin_out_s pin_out,
   output      logic        pins_owned,
   output      logic        port_irq_flag
);
   sp_state_s s_ff;
   sp_state_s nxt_s;

   function automatic logic is_master(input logic [3:0] m);
      return m <= `SP_MODE_TIMER;
   endfunction : is_master

   function automatic logic is_slave(input logic [3:0] m);
      return (m == `SP_MODE_SLAVE_SEL) || (m == `SP_MODE_SLAVE_FREE);
   endfunction : is_slave

   always_comb begin
      logic       wr;
      logic       rd;
      logic       hb;
      logic       chg;
      logic       mid;
      logic       done;
      logic       in_bit;
      logic       active;
      logic       sck_lead;
      logic       sck_trail;
      logic       start;
      logic [7:0] half;
      wr = 1'b0;
      rd = 1'b0;
      hb = 1'b0;
      chg = 1'b0;
      mid = 1'b0;
      done = 1'b0;
      in_bit = 1'b0;
      active = 1'b0;
      sck_lead = 1'b0;
      sck_trail = 1'b0;
      start = 1'b0;
      half = `SP_HALF_DIV4;
      nxt_s = s_ff;

      // Three-stage synchronisers; a level counts once the second and third stages agree.
      nxt_s.sync1 = pin_in;
      nxt_s.sync2 = s_ff.sync1;
      nxt_s.sync3 = s_ff.sync2;
      nxt_s.filt  = (s_ff.filt & (s_ff.sync2 ^ s_ff.sync3)) | (s_ff.sync2 & ~(s_ff.sync2 ^ s_ff.sync3));
      nxt_s.sck_prev = s_ff.filt.sck;

      // APB slave with no wait states: the answer is prepared in the setup cycle.
      nxt_s.pready  = psel && !penable;
      nxt_s.pslverr = 1'b0;
      if (psel && !penable) begin
         nxt_s.prdata = 32'h0000_0000;
         unique case (paddr)
            `SP_OFF_STATUS: begin
               nxt_s.prdata[`SP_ST_SAMPLE_LATE]  = s_ff.sample_late;
               nxt_s.prdata[`SP_ST_TX_IDLE_EDGE] = s_ff.tx_idle_edge;
               nxt_s.prdata[`SP_ST_STOP_SEEN]    = s_ff.stop_seen;
               nxt_s.prdata[`SP_ST_RX_FULL]      = s_ff.rx_buffer_full;
            end
            `SP_OFF_CONTROL: nxt_s.prdata[7:0] = {s_ff.write_collision, s_ff.rx_overflow, s_ff.port_enable,
                                                  s_ff.clock_idle_high, s_ff.port_mode_select};
            `SP_OFF_DATA:    nxt_s.prdata[7:0] = s_ff.data_buffer;
            `SP_OFF_FLAGS:   nxt_s.prdata[`SP_FL_IRQ] = s_ff.port_irq_flag;
            `SP_OFF_TIMER:   nxt_s.prdata[7:0] = s_ff.timer_period;
            default:         nxt_s.pslverr = 1'b1;
         endcase
      end
      wr = psel && penable && s_ff.pready && pwrite && !s_ff.pslverr;
      rd = psel && penable && s_ff.pready && !pwrite && !s_ff.pslverr;

      if (rd && paddr == `SP_OFF_DATA) begin
         nxt_s.rx_buffer_full = 1'b0;
      end
      if (wr) begin
         unique case (paddr)
            `SP_OFF_STATUS: begin
               nxt_s.sample_late  = pwdata[`SP_ST_SAMPLE_LATE];
               nxt_s.tx_idle_edge = pwdata[`SP_ST_TX_IDLE_EDGE];
            end
            `SP_OFF_CONTROL: begin
               nxt_s.write_collision  = pwdata[`SP_CT_WRITE_COLLISION];
               nxt_s.rx_overflow      = pwdata[`SP_CT_OVERFLOW];
               nxt_s.port_enable      = pwdata[`SP_CT_ENABLE];
               nxt_s.clock_idle_high  = pwdata[`SP_CT_IDLE_HIGH];
               nxt_s.port_mode_select = pwdata[3:0];
            end
            `SP_OFF_DATA: begin
               if (s_ff.write_collision || s_ff.eng == SP_MASTER || s_ff.bit_cnt != 3'h0) begin
                  nxt_s.write_collision = 1'b1;
               end else begin
                  nxt_s.data_buffer    = pwdata[7:0];
                  nxt_s.shift_register = pwdata[7:0];
                  nxt_s.pins.sdo_out   = pwdata[7];
                  if (s_ff.port_enable && is_master(s_ff.port_mode_select)) begin
                     nxt_s.eng     = SP_MASTER;
                     nxt_s.step    = 5'h00;
                     nxt_s.bit_cnt = 3'h0;
                     start         = 1'b1;
                  end
               end
            end
            `SP_OFF_FLAGS: begin
               if (pwdata[`SP_FL_IRQ]) begin
                  nxt_s.port_irq_flag = 1'b0;
               end
            end
            `SP_OFF_TIMER: nxt_s.timer_period = pwdata[7:0];
            default: ;
         endcase
      end

      // Period timer and half-bit divider for the master clock.
      if (s_ff.timer_cnt >= s_ff.timer_period) begin
         nxt_s.timer_cnt = 8'h00;
      end else begin
         nxt_s.timer_cnt = s_ff.timer_cnt + 8'h01;
      end
      unique case (s_ff.port_mode_select)
         `SP_MODE_DIV16: half = `SP_HALF_DIV16;
         `SP_MODE_DIV64: half = `SP_HALF_DIV64;
         default:        half = `SP_HALF_DIV4;
      endcase
      if (s_ff.port_mode_select == `SP_MODE_TIMER) begin
         hb = s_ff.timer_cnt >= s_ff.timer_period;
      end else begin
         hb = s_ff.div_cnt == half - 8'h01;
         // A new transfer restarts the divider so that every half bit is full length.
         nxt_s.div_cnt = (hb || start) ? 8'h00 : s_ff.div_cnt + 8'h01;
      end

      unique case (s_ff.eng)
         SP_MASTER: begin
            if (hb) begin
               chg = s_ff.tx_idle_edge ? s_ff.step[0] : (!s_ff.step[0] && s_ff.step != 5'h00);
               mid = (s_ff.tx_idle_edge ? !s_ff.step[0] : s_ff.step[0]) && s_ff.step < `SP_LAST_STEP;
               if (s_ff.step < `SP_LAST_STEP) begin
                  nxt_s.pins.sck_out = s_ff.step[0] ? s_ff.clock_idle_high : !s_ff.clock_idle_high;
               end
               if (mid && !s_ff.sample_late) begin
                  nxt_s.mid_sample = s_ff.filt.sdi;
               end
               if (chg) begin
                  in_bit = s_ff.sample_late ? s_ff.filt.sdi : s_ff.mid_sample;
                  nxt_s.shift_register = {s_ff.shift_register[6:0], in_bit};
                  nxt_s.pins.sdo_out = s_ff.shift_register[6];
                  nxt_s.bit_cnt = s_ff.bit_cnt + 3'h1;
                  done = s_ff.bit_cnt == `SP_LAST_BIT;
               end
               nxt_s.step = s_ff.step + 5'h01;
               if (done) begin
                  nxt_s.eng = SP_IDLE;
               end
            end
         end
         SP_SLAVE: begin
            active = s_ff.port_mode_select == `SP_MODE_SLAVE_FREE || !s_ff.filt.ss_n;
            sck_lead  = s_ff.filt.sck != s_ff.sck_prev && s_ff.filt.sck != s_ff.clock_idle_high;
            sck_trail = s_ff.filt.sck != s_ff.sck_prev && s_ff.filt.sck == s_ff.clock_idle_high;
            if (!active) begin
               nxt_s.bit_cnt = 3'h0;
            end else if (s_ff.tx_idle_edge ? sck_lead : sck_trail) begin
               nxt_s.shift_register = {s_ff.shift_register[6:0], s_ff.filt.sdi};
               nxt_s.bit_cnt = s_ff.bit_cnt + 3'h1;
               done = s_ff.bit_cnt == `SP_LAST_BIT;
            end else if (s_ff.tx_idle_edge ? sck_trail : sck_lead) begin
               nxt_s.pins.sdo_out = s_ff.shift_register[7];
            end
         end
         default: ;
      endcase

      if (done) begin
         nxt_s.port_irq_flag = 1'b1;
         if (s_ff.eng == SP_SLAVE && nxt_s.rx_buffer_full) begin
            nxt_s.rx_overflow = 1'b1;
         end else begin
            nxt_s.data_buffer    = nxt_s.shift_register;
            nxt_s.rx_buffer_full = 1'b1;
         end
      end

      if (!nxt_s.port_enable) begin
         nxt_s.eng       = SP_IDLE;
         nxt_s.bit_cnt   = 3'h0;
         nxt_s.stop_seen = 1'b0;
      end else if (is_slave(nxt_s.port_mode_select)) begin
         nxt_s.eng = SP_SLAVE;
      end else if (!is_master(nxt_s.port_mode_select)) begin
         nxt_s.eng = SP_IDLE;
      end else if (nxt_s.eng == SP_SLAVE) begin
         nxt_s.eng = SP_IDLE;
      end
      if (nxt_s.eng != SP_MASTER) begin
         nxt_s.pins.sck_out = nxt_s.clock_idle_high;
      end
      nxt_s.pins_owned  = nxt_s.port_enable;
      nxt_s.pins.sck_oe = nxt_s.port_enable && is_master(nxt_s.port_mode_select);
      nxt_s.pins.sdo_oe = nxt_s.port_enable && (is_master(nxt_s.port_mode_select) ||
                          nxt_s.port_mode_select == `SP_MODE_SLAVE_FREE ||
                          (nxt_s.port_mode_select == `SP_MODE_SLAVE_SEL && !nxt_s.filt.ss_n));
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_ff              <= '0;
         s_ff.eng          <= SP_IDLE;
         s_ff.timer_period <= `SP_TIMER_RESET;
         s_ff.sync1        <= '1;
         s_ff.sync2        <= '1;
         s_ff.sync3        <= '1;
         s_ff.filt         <= '1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign prdata        = s_ff.prdata;
   assign pready        = s_ff.pready;
   assign pslverr       = s_ff.pslverr;
   assign pin_out       = s_ff.pins;
   assign pins_owned    = s_ff.pins_owned;
   assign port_irq_flag = s_ff.port_irq_flag;
endmodule : sp_spi_port

// file: dv/sp_spi_port_sva.sv
// Assertions on the ports of the SPI serial port.
// Assumes it is bound to sp_spi_port and software clears flags before each master transfer.
`timescale 1ns/10ps
module sp_spi_port_sva
   import sp_spi_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire sp_pin_in_s  pin_in,
   input wire sp_pin_out_s pin_out,
   input wire logic        pins_owned,
   input wire logic        port_irq_flag
);
   logic [7:0] ctl_ff;
   logic       bsy_ff;
   logic [9:0] cnt_ff;
   logic       wr;
   logic       dwr;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign wr  = psel && penable && pready && pwrite;
   assign dwr = wr && paddr == 8'h08 && ctl_ff[5] && ctl_ff[3:2] == 2'h0 && !bsy_ff;
   function automatic int hb(input logic [1:0] m);
      return (m == 2'h0) ? 2 : (m == 2'h1) ? 8 : 32;
   endfunction : hb
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_ff <= 8'h00;
         bsy_ff <= 1'b0;
         cnt_ff <= 10'h000;
      end else begin
         if (wr && paddr == 8'h04) ctl_ff <= pwdata[7:0];
         if (dwr) bsy_ff <= 1'b1;
         else if ($rose(port_irq_flag)) bsy_ff <= 1'b0;
         cnt_ff <= dwr ? 10'h000 : cnt_ff + 10'h001;
      end
   end
   sequence s_setup;
      psel && !penable;
   endsequence : s_setup
   AST_PREADY: assert property (s_setup |=> pready) else $error("no answer after setup");
   AST_PREADY_ONE: assert property (pready |=> !pready) else $error("pready held too long");
   AST_OWN: assert property (wr && paddr == 8'h04 |-> ##2 pins_owned == ctl_ff[5])
      else $error("pin ownership does not follow enable");
   AST_FREE: assert property (!pins_owned [*2] |-> !pin_out.sck_oe && !pin_out.sdo_oe)
      else $error("pins driven while port disabled");
   AST_START: assert property (dwr |=> pin_out.sdo_out == $past(pwdata[7]) && pin_out.sck_out == ctl_ff[4])
      else $error("transfer start wrong");
   AST_RATE: assert property ($rose(port_irq_flag) && bsy_ff && ctl_ff[1:0] != 2'h3 |->
      cnt_ff >= 16 * hb(ctl_ff[1:0]) - 2 && cnt_ff <= 17 * hb(ctl_ff[1:0]) + 8)
      else $error("master bit rate wrong");
   AST_IDLE: assert property ($rose(port_irq_flag) && bsy_ff |-> pin_out.sck_out == ctl_ff[4])
      else $error("clock not idle after byte");
   AST_SS: assert property ((ctl_ff[5] && ctl_ff[3:0] == 4'h4 && pin_in.ss_n) [*6] |-> !pin_out.sdo_oe)
      else $error("data out driven while deselected");
   AST_RESET: assert property ($rose(presetn) |-> !pins_owned && !port_irq_flag && !pready)
      else $error("port active after reset");
endmodule : sp_spi_port_sva

// file: dv/sp_spi_far.sv
// Far-side SPI device: a slave while the port masters, a clock source while the port is a slave.
// Assumes transmit-edge set while the port masters; the port's released pins read as idle.
`timescale 1ns/10ps
module sp_spi_far
   import sp_spi_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        cpol,
   input  wire logic        drv_clk,
   input  wire sp_pin_out_s pin_out,
   output      sp_pin_in_s  pin_in,
   output      logic [7:0]  rx_byte
);
   logic [7:0] sh;
   logic       sck_m;
   logic       ss_m;
   logic       sd;
   logic       prev;
   initial begin
      sh = 8'h00;
      sck_m = 1'b0;
      ss_m = 1'b1;
      sd = 1'b0;
      prev = 1'b0;
   end
   assign pin_in.sck  = drv_clk ? (sck_m ^ cpol) : (pin_out.sck_oe ? pin_out.sck_out : cpol);
   assign pin_in.ss_n = ss_m;
   assign pin_in.sdi  = sd;
   always @(posedge pclk) begin
      prev <= pin_in.sck;
      if (!drv_clk && prev != pin_in.sck) begin
         if (pin_in.sck == cpol) begin
            sh <= {sh[6:0], ~sh[7]};
            sd <= sh[6];
         end else begin
            rx_byte <= {rx_byte[6:0], pin_out.sdo_out};
         end
      end
   end
   task automatic load(input logic [7:0] b);
      sh <= b;
      sd <= b[7];
   endtask : load
   task automatic xfer(input logic [7:0] b);
      ss_m <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         repeat (8) @(posedge pclk);
         sd <= b[i];
         repeat (8) @(posedge pclk);
         sck_m <= 1'b1;
         repeat (16) @(posedge pclk);
         rx_byte <= {rx_byte[6:0], pin_out.sdo_out};
         sck_m <= 1'b0;
      end
      repeat (16) @(posedge pclk);
      ss_m <= 1'b1;
      sd <= ~b[0];
      repeat (16) @(posedge pclk);
   endtask : xfer
endmodule : sp_spi_far

// file: dv/tb_sp_spi_port.sv
// Self-checking testbench for the SPI serial port.
// Assumes the design answers APB in one access cycle.
`timescale 1ns/10ps
module tb_sp_spi_port import sp_spi_pkg::*;;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pins_owned, irq, cpol, drv, se;
   logic [7:0]  paddr, rxb;
   logic [31:0] pwdata, prdata, q;
   sp_pin_in_s  pin_in;
   sp_pin_out_s pin_out;
   int          error_cnt, checks;
   sp_spi_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pin_in(pin_in), .pin_out(pin_out), .pins_owned(pins_owned), .port_irq_flag(irq));
   sp_spi_far u_far (.pclk(pclk), .cpol(cpol), .drv_clk(drv), .pin_out(pin_out), .pin_in(pin_in),
      .rx_byte(rxb));
   always #2 pclk = ~pclk;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      chk(pready, 1'b1);
      q = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic wirq();
      for (int n = 0; n < 2000 && irq !== 1'b1; n++) @(posedge pclk);
      chk(irq, 1'b1);
   endtask : wirq
   task automatic t_reset();
      logic [7:0] a [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
      logic [7:0] e [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF};
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, a[i], 32'h0);
         chk(q, e[i]);
      end
      apb(1'b0, 8'h14, 32'h0);
      chk(se, 1'b1);
      chk(q, 32'h0);
      apb(1'b1, 8'h00, 32'hFF);
      apb(1'b0, 8'h00, 32'h0);
      chk(q, 32'hC0);
   endtask : t_reset
   task automatic t_master();
      logic [7:0] c, d;
      apb(1'b1, 8'h00, 32'h40);
      apb(1'b1, 8'h10, 32'h07);
      for (int k = 0; k < 8; k++) begin
         c = {3'b001, k[0], 2'b00, k[2:1]};
         apb(1'b1, 8'h04, c & 8'hDF);
         cpol <= k[0];
         apb(1'b1, 8'h00, (k > 2 && k[0]) ? 32'hC0 : 32'h40);
         apb(1'b1, 8'h04, c);
         apb(1'b1, 8'h0C, 32'h1);
         d = 8'h96 ^ k[7:0];
         u_far.load(~d);
         apb(1'b1, 8'h08, d);
         if (k == 2) apb(1'b1, 8'h08, 32'h0);
         wirq();
         apb(1'b0, 8'h00, 32'h0);
         chk(q, (k > 2 && k[0]) ? 32'hC1 : 32'h41);
         apb(1'b0, 8'h08, 32'h0);
         if (k > 1) chk(q, 8'hFF & ~d);
         chk(rxb, d);
         apb(1'b0, 8'h00, 32'h0);
         chk(q, (k > 2 && k[0]) ? 32'hC0 : 32'h40);
         apb(1'b0, 8'h04, 32'h0);
         chk(q, c | (k == 2 ? 8'h80 : 8'h00));
         apb(1'b1, 8'h04, c);
      end
   endtask : t_master
   task automatic t_slave();
      apb(1'b1, 8'h04, 32'h0);
      drv <= 1'b1;
      cpol <= 1'b0;
      for (int m = 4; m < 6; m++) begin
         apb(1'b1, 8'h04, m);
         apb(1'b1, 8'h00, m == 4 ? 32'h40 : 32'h00);
         apb(1'b1, 8'h04, 32'h20 | m);
         apb(1'b1, 8'h08, 32'h3C + m);
         u_far.xfer(8'hC0 + m[7:0]);
         chk(rxb, 32'h3C + m);
         apb(1'b0, 8'h08, 32'h0);
         chk(q, 32'hC0 + m);
         apb(1'b1, 8'h04, 32'h0);
      end
      apb(1'b1, 8'h04, 32'h24);
      u_far.xfer(8'h11);
      u_far.xfer(8'h22);
      apb(1'b0, 8'h04, 32'h0);
      chk(q, 32'h64);
      apb(1'b0, 8'h08, 32'h0);
      chk(q, 32'h11);
      apb(1'b1, 8'h04, 32'h0);
      apb(1'b0, 8'h00, 32'h0);
      chk(q, 32'h00);
      chk(pins_owned, 1'b0);
   endtask : t_slave
   task automatic t_abort();
      apb(1'b1, 8'h04, 32'h22);
      apb(1'b1, 8'h08, 32'hA5);
      repeat (40) @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk(pins_owned, 1'b0);
      @(posedge pclk);
      apb(1'b0, 8'h04, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, 8'h08, 32'h0);
      chk(q, 32'h0);
      chk(irq, 1'b0);
   endtask : t_abort
   task automatic end_of_test();
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   initial begin
      {pclk, presetn, psel, penable, pwrite, cpol, drv} = 7'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      error_cnt = 0;
      checks = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_master();
      t_slave();
      t_abort();
      end_of_test();
   end
   initial begin
      repeat (60000) @(posedge pclk);
      error_cnt++;
      end_of_test();
   end
endmodule : tb_sp_spi_port
bind sp_spi_port sp_spi_port_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pin_in(pin_in), .pin_out(pin_out), .pins_owned(pins_owned), .port_irq_flag(port_irq_flag));
